//--- hw/irqmb_bank.sv
`timescale 1ns/1ps
module irqmb_bank (
	// Clock and reset.
	input  wire logic                       mclk,
	input  wire logic                       reset_n,
	// Register bus.
	input  wire irqmb_pkg::irqmb_wb_req_type wb_req,
	output irqmb_pkg::irqmb_wb_rsp_type     wb_rsp,
	// Event sources.
	input  wire irqmb_pkg::irqmb_event_type events,
	// Toward the monitor bank.
	output irqmb_pkg::irqmb_bank_type       mask_bits,
	output irqmb_pkg::irqmb_bank_type       gated_bits
);
	import irqmb_pkg::*;

	// Decodes a byte address to a slot of the mask bank.
	function automatic logic [SLOT_W:0] bank_slot(input logic [WB_AW-1:0] adr);
		logic [9:0] idx;
		logic [9:0] rel;
		idx = adr[WB_AW-1:2];
		rel = idx - FIRST_MASK_IDX;
		if (idx >= FIRST_MASK_IDX && rel < 10'(MASK_COUNT)) begin
			bank_slot = {1'b1, rel[SLOT_W-1:0]};
		end else begin
			bank_slot = '0;
		end
	endfunction

	// Places a pair of reference inputs into register layout.
	function automatic irqmb_byte_type pack_ref_pair(input irqmb_ref_ev_type lo,
		input irqmb_ref_ev_type hi);
		irqmb_byte_type r;
		r = '0;
		r[REF_FAULT_BIT]                     = lo.fault;
		r[REF_CLEARED_BIT]                   = lo.fault_cleared;
		r[REF_VALID_BIT]                     = lo.validated;
		r[REF_FAULT_BIT + REF_UPPER_SHIFT]   = hi.fault;
		r[REF_CLEARED_BIT + REF_UPPER_SHIFT] = hi.fault_cleared;
		r[REF_VALID_BIT + REF_UPPER_SHIFT]   = hi.validated;
		return r;
	endfunction

	// Places a loop's lock events into register layout.
	function automatic irqmb_byte_type pack_lock(input irqmb_loop_ev_type ev);
		irqmb_byte_type r;
		r = '0;
		r[FREQ_UNCLAMP_BIT] = ev.freq_unclamped;
		r[FREQ_CLAMP_BIT]   = ev.freq_clamped;
		r[SLEW_UNLIMIT_BIT] = ev.slew_unlimited;
		r[SLEW_LIMIT_BIT]   = ev.slew_limited;
		r[FREQ_UNLOCK_BIT]  = ev.freq_unlocked;
		r[FREQ_LOCK_BIT]    = ev.freq_locked;
		r[PHASE_UNLOCK_BIT] = ev.phase_unlocked;
		r[PHASE_LOCK_BIT]   = ev.phase_locked;
		return r;
	endfunction

	// Places a loop's mode and activation events into register layout.
	function automatic irqmb_byte_type pack_state(input irqmb_loop_ev_type ev);
		irqmb_byte_type r;
		r = '0;
		r[SWITCH_BIT]   = ev.switching;
		r[FREE_RUN_BIT] = ev.free_run;
		r[HOLDOVER_BIT] = ev.holdover;
		r[HISTORY_BIT]  = ev.history_updated;
		r[ACTIVATED_LSB +: 4] = ev.ref_activated;
		return r;
	endfunction

	// Places a loop's sync and analog events into register layout.
	function automatic irqmb_byte_type pack_analog(input irqmb_loop_ev_type ev);
		irqmb_byte_type r;
		r = '0;
		r[DIST_SYNC_BIT]   = ev.dist_sync;
		r[ANA_UNLOCK_BIT]  = ev.analog_unlocked;
		r[ANA_LOCK_BIT]    = ev.analog_locked;
		r[ANA_CAL_END_BIT] = ev.analog_cal_done;
		r[ANA_CAL_GO_BIT]  = ev.analog_cal_started;
		return r;
	endfunction

	// Bus decode state.
	logic [SLOT_W:0]   slot;
	logic              slot_hit;
	logic              summary_hit;
	logic              bus_req;
	logic              wr_commit;
	logic              next_ack;
	logic [WB_DW-1:0]  next_rd_data;
	logic [WB_DW-1:0]  rd_data;
	logic              ack;

	// Mask bank and gating state.
	irqmb_bank_type    masks;
	irqmb_bank_type    layout;
	irqmb_bank_type    next_gated;
	logic [MASK_COUNT-1:0] wr_en;
	logic [MASK_COUNT:0]   gate_summary;

	assign slot        = bank_slot(wb_req.adr);
	assign slot_hit    = slot[SLOT_W];
	assign summary_hit = (wb_req.adr[WB_AW-1:2] == GATE_SUMMARY_IDX);
	assign bus_req     = wb_req.cyc & wb_req.stb;

	// A write lands on the edge at which the master sees ack, so it is applied exactly once.
	assign wr_commit   = bus_req & wb_req.we & ack & wb_req.sel[0];

	always_comb begin
		wr_en = '0;
		if (wr_commit && slot_hit) begin
			wr_en[slot[SLOT_W-1:0]] = 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < MASK_COUNT; gi++) begin : g_mask
			irqmb_mask_reg #(
				.WRITABLE (BANK_WRITABLE[gi])
			) u_mask (
				.mclk    (mclk),
				.reset_n (reset_n),
				.wr_en   (wr_en[gi]),
				.wr_data (wb_req.dat[DATA_W-1:0]),
				.value   (masks[gi])
			);
		end
	endgenerate

	// Reports which mask registers currently let anything through.
	always_comb begin
		gate_summary = '0;
		for (int i = 0; i < MASK_COUNT; i++) begin
			gate_summary[i] = |masks[i];
		end
		gate_summary[MASK_COUNT] = |gate_summary[MASK_COUNT-1:0];
	end

	// Event layout matches the monitor bank bit for bit.
	always_comb begin
		layout = '0;
		layout[SLOT_SYS][SYS_PLL_UNLOCK_BIT] = events.sys.pll_unlocked;
		layout[SLOT_SYS][SYS_PLL_STABLE_BIT] = events.sys.pll_stable;
		layout[SLOT_SYS][SYS_PLL_LOCK_BIT]   = events.sys.pll_locked;
		layout[SLOT_SYS][WATCHDOG_BIT]       = events.sys.watchdog_expired;
		layout[SLOT_SYS][NVM_FAULT_BIT]      = events.sys.nvm_fault;
		layout[SLOT_SYS][NVM_DONE_BIT]       = events.sys.nvm_done;
		layout[SLOT_REF_LOW]  = pack_ref_pair(events.ref_input[0], events.ref_input[1]);
		layout[SLOT_REF_HIGH] = pack_ref_pair(events.ref_input[2], events.ref_input[3]);
		layout[SLOT_LOOP0 + OFS_LOCK]   = pack_lock(events.loop[0]);
		layout[SLOT_LOOP0 + OFS_STATE]  = pack_state(events.loop[0]);
		layout[SLOT_LOOP0 + OFS_ANALOG] = pack_analog(events.loop[0]);
		layout[SLOT_LOOP1 + OFS_LOCK]   = pack_lock(events.loop[1]);
		layout[SLOT_LOOP1 + OFS_STATE]  = pack_state(events.loop[1]);
		layout[SLOT_LOOP1 + OFS_ANALOG] = pack_analog(events.loop[1]);
	end

	// Gating is registered so the monitor sees a clean one-cycle-late copy of each event.
	always_comb begin
		for (int i = 0; i < MASK_COUNT; i++) begin
			next_gated[i] = layout[i] & masks[i] & BANK_WRITABLE[i];
		end
	end

	// Bus answer: one wait cycle, then ack for a single cycle; unmapped reads return zero.
	always_comb begin
		next_ack     = bus_req & ~ack;
		next_rd_data = '0;
		if (bus_req && !ack) begin
			if (slot_hit) begin
				next_rd_data[DATA_W-1:0] = masks[slot[SLOT_W-1:0]];
			end else if (summary_hit) begin
				next_rd_data[MASK_COUNT:0] = gate_summary;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ack        <= 1'b0;
			rd_data    <= '0;
			gated_bits <= '0;
		end else begin
			ack        <= next_ack;
			rd_data    <= next_rd_data;
			gated_bits <= next_gated;
		end
	end

	assign wb_rsp.ack = ack;
	assign wb_rsp.dat = rd_data;
	assign mask_bits  = masks;

endmodule

//--- shared/irqmb_pkg.sv
package irqmb_pkg;

	// Bank geometry and bus widths.
	localparam int MASK_COUNT = 9;
	localparam int DATA_W     = 8;
	localparam int WB_DW      = 32;
	localparam int WB_AW      = 12;
	localparam int SLOT_W     = 4;

	typedef logic [DATA_W-1:0] irqmb_byte_type;
	typedef irqmb_byte_type [MASK_COUNT-1:0] irqmb_bank_type;

	// Register indices; the byte address is four times the index.
	localparam logic [9:0] SYS_MASK_IDX       = 10'h10a;
	localparam logic [9:0] REF_LOW_MASK_IDX   = 10'h10b;
	localparam logic [9:0] REF_HIGH_MASK_IDX  = 10'h10c;
	localparam logic [9:0] LOOP0_LOCK_IDX     = 10'h10d;
	localparam logic [9:0] LOOP0_STATE_IDX    = 10'h10e;
	localparam logic [9:0] LOOP0_ANALOG_IDX   = 10'h10f;
	localparam logic [9:0] LOOP1_LOCK_IDX     = 10'h110;
	localparam logic [9:0] LOOP1_STATE_IDX    = 10'h111;
	localparam logic [9:0] LOOP1_ANALOG_IDX   = 10'h112;
	localparam logic [9:0] GATE_SUMMARY_IDX   = 10'h113;
	localparam logic [9:0] FIRST_MASK_IDX     = SYS_MASK_IDX;

	// Slots within the bank, in address order.
	localparam int SLOT_SYS      = 0;
	localparam int SLOT_REF_LOW  = 1;
	localparam int SLOT_REF_HIGH = 2;
	localparam int SLOT_LOOP0    = 3;
	localparam int SLOT_LOOP1    = 6;
	localparam int OFS_LOCK      = 0;
	localparam int OFS_STATE     = 1;
	localparam int OFS_ANALOG    = 2;

	// System register field positions.
	localparam int SYS_PLL_UNLOCK_BIT = 6;
	localparam int SYS_PLL_STABLE_BIT = 5;
	localparam int SYS_PLL_LOCK_BIT   = 4;
	localparam int WATCHDOG_BIT       = 3;
	localparam int NVM_FAULT_BIT      = 1;
	localparam int NVM_DONE_BIT       = 0;

	// Reference register field positions, per input of a pair.
	localparam int REF_FAULT_BIT   = 0;
	localparam int REF_CLEARED_BIT = 1;
	localparam int REF_VALID_BIT   = 2;
	localparam int REF_UPPER_SHIFT = 4;

	// Loop lock register field positions.
	localparam int FREQ_UNCLAMP_BIT = 7;
	localparam int FREQ_CLAMP_BIT   = 6;
	localparam int SLEW_UNLIMIT_BIT = 5;
	localparam int SLEW_LIMIT_BIT   = 4;
	localparam int FREQ_UNLOCK_BIT  = 3;
	localparam int FREQ_LOCK_BIT    = 2;
	localparam int PHASE_UNLOCK_BIT = 1;
	localparam int PHASE_LOCK_BIT   = 0;

	// Loop state register field positions.
	localparam int SWITCH_BIT     = 7;
	localparam int FREE_RUN_BIT   = 6;
	localparam int HOLDOVER_BIT   = 5;
	localparam int HISTORY_BIT    = 4;
	localparam int ACTIVATED_LSB  = 0;

	// Loop analog register field positions.
	localparam int DIST_SYNC_BIT   = 4;
	localparam int ANA_UNLOCK_BIT  = 3;
	localparam int ANA_LOCK_BIT    = 2;
	localparam int ANA_CAL_END_BIT = 1;
	localparam int ANA_CAL_GO_BIT  = 0;

	// Writable positions and reset value.
	localparam irqmb_byte_type SYS_WRITABLE    = 8'h7b;
	localparam irqmb_byte_type REF_WRITABLE    = 8'h77;
	localparam irqmb_byte_type LOCK_WRITABLE   = 8'hff;
	localparam irqmb_byte_type STATE_WRITABLE  = 8'hff;
	localparam irqmb_byte_type ANALOG_WRITABLE = 8'h1f;
	localparam irqmb_byte_type MASK_RESET      = 8'h00;
	localparam irqmb_bank_type BANK_WRITABLE   = {ANALOG_WRITABLE, STATE_WRITABLE, LOCK_WRITABLE,
		ANALOG_WRITABLE, STATE_WRITABLE, LOCK_WRITABLE, REF_WRITABLE, REF_WRITABLE, SYS_WRITABLE};

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [WB_AW-1:0] adr;
		logic [WB_DW-1:0] dat;
	} irqmb_wb_req_type;

	typedef struct packed {
		logic ack;
		logic [WB_DW-1:0] dat;
	} irqmb_wb_rsp_type;

	typedef struct packed {
		logic pll_unlocked;
		logic pll_stable;
		logic pll_locked;
		logic watchdog_expired;
		logic nvm_fault;
		logic nvm_done;
	} irqmb_sys_ev_type;

	typedef struct packed {
		logic validated;
		logic fault_cleared;
		logic fault;
	} irqmb_ref_ev_type;

	typedef struct packed {
		logic freq_unclamped;
		logic freq_clamped;
		logic slew_unlimited;
		logic slew_limited;
		logic freq_unlocked;
		logic freq_locked;
		logic phase_unlocked;
		logic phase_locked;
		logic switching;
		logic free_run;
		logic holdover;
		logic history_updated;
		logic [3:0] ref_activated;
		logic dist_sync;
		logic analog_unlocked;
		logic analog_locked;
		logic analog_cal_done;
		logic analog_cal_started;
	} irqmb_loop_ev_type;

	typedef struct packed {
		irqmb_sys_ev_type sys;
		irqmb_ref_ev_type [3:0] ref_input;
		irqmb_loop_ev_type [1:0] loop;
	} irqmb_event_type;

endpackage

//--- hw/irqmb_mask_reg.sv
`timescale 1ns/1ps
module irqmb_mask_reg #(
	parameter irqmb_pkg::irqmb_byte_type WRITABLE = 8'hff
) (
	// Clock and reset.
	input  wire logic                    mclk,
	input  wire logic                    reset_n,
	// Write port.
	input  wire logic                    wr_en,
	input  wire irqmb_pkg::irqmb_byte_type wr_data,
	// Stored mask.
	output irqmb_pkg::irqmb_byte_type    value
);
	import irqmb_pkg::*;

	irqmb_byte_type next_value;

	always_comb begin
		next_value = value;
		if (wr_en) begin
			next_value = wr_data & WRITABLE;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			value <= MASK_RESET;
		end else begin
			value <= next_value;
		end
	end

endmodule

//--- verif/irqmb_bank_props.sv
`timescale 1ns/1ps
module irqmb_bank_props (
	// Clock and reset.
	input wire logic                        mclk,
	input wire logic                        reset_n,
	// Register bus.
	input wire irqmb_pkg::irqmb_wb_req_type wb_req,
	input wire irqmb_pkg::irqmb_wb_rsp_type wb_rsp,
	// Events and results.
	input wire irqmb_pkg::irqmb_event_type  events,
	input wire irqmb_pkg::irqmb_bank_type   mask_bits,
	input wire irqmb_pkg::irqmb_bank_type   gated_bits
);
	import irqmb_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	reset_clear_a: assert property (
		$rose(reset_n) |-> mask_bits == '0 && gated_bits == '0) else $error("masks not clear after reset");
	mask_gate_a: assert property (
		(gated_bits & ~$past(mask_bits)) == '0) else $error("event passed a clear mask");
	reserved_zero_a: assert property (
		(mask_bits & 72'he00000e00000888884) == '0) else $error("reserved mask bit set");
	sys_write_a: assert property (
		wb_rsp.ack && wb_req.we && wb_req.sel[0] && wb_req.adr == 12'h428
		|=> mask_bits[0] == ($past(wb_req.dat[7:0]) & 8'h7b)) else $error("system mask write wrong");
	watchdog_gate_a: assert property (
		events.sys.watchdog_expired && mask_bits[0][3] |=> gated_bits[0][3]) else $error("watchdog lost");
	nvm_gate_a: assert property (
		events.sys.nvm_done && mask_bits[0][0] |=> gated_bits[0][0]) else $error("memory done lost");
	ref_gate_a: assert property (
		events.ref_input[3].validated && mask_bits[2][6] |=> gated_bits[2][6]) else $error("ref d lost");
	loop_lock_a: assert property (
		events.loop[0].freq_unclamped && mask_bits[3][7] |=> gated_bits[3][7]) else $error("unclamp lost");
	loop_state_a: assert property (
		events.loop[0].ref_activated[0] && mask_bits[4][0] |=> gated_bits[4][0]) else $error("ref a lost");
	loop_analog_a: assert property (
		events.loop[0].dist_sync && mask_bits[5][4] |=> gated_bits[5][4]) else $error("sync lost");
	loop1_map_a: assert property (
		events.loop[1].switching && mask_bits[7][7] |=> gated_bits[7][7]) else $error("loop 1 switch lost");

	cover property (wb_rsp.ack && wb_req.we);
	cover property (gated_bits != '0);
	cover property ($rose(reset_n));
endmodule

bind irqmb_bank irqmb_bank_props props_u (.mclk(mclk), .reset_n(reset_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
	.events(events), .mask_bits(mask_bits), .gated_bits(gated_bits));

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
	import irqmb_pkg::*;
	logic             mclk = 1'b0;
	logic             reset_n = 1'b0;
	irqmb_wb_req_type req = '0;
	irqmb_wb_rsp_type rsp;
	irqmb_event_type  ev = '0;
	irqmb_bank_type   mask_bits;
	irqmb_bank_type   gated_bits;
	irqmb_bank_type   m = '0;
	irqmb_bank_type   e1 = '0;
	irqmb_bank_type   e2 = '0;
	int               error_cnt = 0;
	int               num_checks = 0;
	logic [31:0]      q;
	// Writable positions per slot; reserved bits must read back clear.
	localparam irqmb_bank_type WM = {8'h1f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'h77, 8'h77, 8'h7b};

	always #20 mclk = ~mclk;

	irqmb_bank dut_u (.mclk(mclk), .reset_n(reset_n), .wb_req(req), .wb_rsp(rsp), .events(ev),
		.mask_bits(mask_bits), .gated_bits(gated_bits));

	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [71:0] got, input logic [71:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// Upper data bits are random because the block must ignore them.
	task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
		int n;
		req <= {1'b1, 1'b1, we, s, a, 24'($urandom), d};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (rsp.ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk(72'h0, 72'h1);
			test_done();
		end
		q = rsp.dat;
		req <= '0;
		@(posedge mclk);
	endtask

	function automatic irqmb_bank_type lay(input irqmb_event_type e);
		irqmb_bank_type b;
		b = '0;
		b[0] = {1'b0, e.sys[5:2], 1'b0, e.sys[1:0]};
		for (int i = 0; i < 2; i++) begin
			b[1+i] = {1'b0, e.ref_input[2*i+1], 1'b0, e.ref_input[2*i]};
		end
		for (int l = 0; l < 2; l++) begin
			b[3+3*l] = e.loop[l][20:13];
			b[4+3*l] = e.loop[l][12:5];
			b[5+3*l] = {3'h0, e.loop[l][4:0]};
		end
		return b;
	endfunction

	// Gate summary: one bit per mask register that holds any set bit, top bit for the whole bank.
	function automatic logic [9:0] summ(input irqmb_bank_type b);
		for (int i = 0; i < 9; i++) begin
			summ[i] = |b[i];
		end
		summ[9] = |b;
	endfunction

	// Two-stage expectation: events land in the gated output one cycle after they are sampled.
	task automatic ev_run(input int n);
		logic [63:0] r;
		e1 = '0;
		e2 = '0;
		repeat (n) begin
			@(posedge mclk);
			chk(gated_bits, e2);
			r = {$urandom, $urandom};
			ev <= r[59:0];
			e2 = e1;
			e1 = lay(r[59:0]) & m;
		end
		// The last two drawn event sets are still in flight and are checked here.
		@(posedge mclk);
		chk(gated_bits, e2);
		ev <= '0;
		@(posedge mclk);
		chk(gated_bits, e1);
		@(posedge mclk);
	endtask

	initial begin
		logic [7:0] d;
		void'($urandom(72));
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		for (int s = 0; s < 9; s++) begin
			wb(1'b0, 12'h428 + 12'(4*s), 8'h00, 4'hf);
			chk(72'(q), 72'h0);
		end
		wb(1'b0, 12'h44c, 8'h00, 4'hf);
		chk(72'(q), 72'h0);
		ev_run(40);
		for (int k = 0; k < 4; k++) begin
			for (int s = 0; s < 9; s++) begin
				d = (k == 0) ? 8'hff : 8'($urandom);
				wb(1'b1, 12'h428 + 12'(4*s), d, {3'($urandom), 1'b1});
				m[s] = d & WM[s];
			end
			wb(1'b1, 12'h428 + 12'(4*($urandom % 9)), 8'($urandom), 4'he);
			wb(1'b1, 12'h450, 8'hff, 4'hf);
			wb(1'b0, 12'h450, 8'h00, 4'hf);
			chk(72'(q), 72'h0);
			for (int s = 0; s < 9; s++) begin
				wb(1'b0, 12'h428 + 12'(4*s), 8'h00, 4'hf);
				chk(72'(q), 72'(m[s]));
			end
			// The summary is read-only, so a write to it must leave it showing the masks.
			wb(1'b1, 12'h44c, 8'h00, 4'hf);
			wb(1'b0, 12'h44c, 8'h00, 4'hf);
			chk(72'(q), 72'(summ(m)));
			chk(mask_bits, m);
			ev_run(60);
		end
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		chk(mask_bits, 72'h0);
		wb(1'b0, 12'h44c, 8'h00, 4'hf);
		chk(72'(q), 72'h0);
		m = '0;
		ev_run(20);
		test_done();
	end
endmodule
